// ### shared/lra_ol_cfg.svh
`ifndef LRA_OL_CFG_SVH
`define LRA_OL_CFG_SVH
// Register offsets
`define OFS_FALLBACK_CTRL 8'h2C
`define OFS_PERIOD_HIGH 8'h2E
`define OFS_PERIOD_LOW 8'h2F
// Control field positions
`define BIT_AUTO_FALLBACK 7
`define POS_ATTEMPT_HI 6
`define POS_ATTEMPT_LO 5
`define BIT_SHAPE 0
// Reset values
`define RST_FALLBACK_CTRL 8'h00
`define RST_PERIOD 10'h0C6
// Attempt threshold for code 0
`define ATTEMPT_BASE 3'h3
// Open-loop period step: 24.615 us, in ns
`define STEP_NS 24615
`define CLK_NS 100
// Cycles per step, rounded down (shorter step)
`define STEP_CYC (`STEP_NS / `CLK_NS)
`endif

// ### shared/lra_ol_pkg.sv
package lra_ol_pkg;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CLOSED,
        ST_OPEN
    } loop_state_t;
    typedef enum logic {
        SHAPE_SQUARE,
        SHAPE_SINE
    } shape_t;
endpackage

// ### hdl/lra_open_loop_fallback_ctrl.sv
`timescale 1ns/1ns
`include "lra_ol_cfg.svh"
module lra_open_loop_fallback_ctrl (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic drive_start,
    input wire logic drive_stop,
    input wire logic force_open_loop,
    input wire logic zero_cross_event,
    input wire logic zero_cross_miss,
    output lra_ol_pkg::loop_state_t loop_state,
    output lra_ol_pkg::shape_t drive_shape,
    output logic open_loop_active,
    output logic period_tick,
    output logic drive_phase
);
    import lra_ol_pkg::*;

    logic [7:0] ctrl_ff;
    logic [9:0] period_ff;
    loop_state_t state_ff;
    loop_state_t nxt_state;
    logic [2:0] fail_ff;
    logic [2:0] nxt_fail;
    logic fallback_ff;
    logic nxt_fallback;
    logic [7:0] step_ff;
    logic [9:0] unit_ff;
    logic tick_ff;
    logic phase_ff;

    wire sel_ctrl = reg_addr == `OFS_FALLBACK_CTRL;
    wire sel_hi = reg_addr == `OFS_PERIOD_HIGH;
    wire sel_lo = reg_addr == `OFS_PERIOD_LOW;
    wire auto_en = ctrl_ff[`BIT_AUTO_FALLBACK];
    wire [1:0] attempt_code = ctrl_ff[`POS_ATTEMPT_HI:`POS_ATTEMPT_LO];
    // Code 0..3 maps to 3..6 failures
    wire [2:0] threshold = `ATTEMPT_BASE + {1'b0, attempt_code};
    wire fail_hit = (fail_ff + 3'h1) >= threshold;

    // Read data per register; unused high bits read as zero
    wire [7:0] rd_ctrl = ctrl_ff;
    wire [7:0] rd_hi = {6'h00, period_ff[9:8]};
    wire [7:0] rd_lo = period_ff[7:0];

    // Reads decode the same offsets; unmapped reads return zero
    always_comb begin
        if (sel_ctrl) begin
            reg_rdata = rd_ctrl;
        end else if (sel_hi) begin
            reg_rdata = rd_hi;
        end else if (sel_lo) begin
            reg_rdata = rd_lo;
        end else begin
            reg_rdata = 8'h00;
        end
    end

    // Write decode; one strobe per register
    wire wr_ctrl = reg_wr && sel_ctrl;
    wire wr_hi = reg_wr && sel_hi;
    wire wr_lo = reg_wr && sel_lo;
    wire [7:0] nxt_ctrl = wr_ctrl ? reg_wdata : ctrl_ff;
    // Each byte lands alone; the other half keeps its value
    wire [9:0] nxt_period = wr_hi ? {reg_wdata[1:0], period_ff[7:0]}
        : wr_lo ? {period_ff[9:8], reg_wdata} : period_ff;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_ff <= `RST_FALLBACK_CTRL;
        end else begin
            ctrl_ff <= nxt_ctrl;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            period_ff <= `RST_PERIOD;
        end else begin
            period_ff <= nxt_period;
        end
    end

    always_comb begin
        nxt_state = state_ff;
        nxt_fail = fail_ff;
        nxt_fallback = fallback_ff;
        case (state_ff)
            ST_IDLE: begin
                if (drive_start) begin
                    nxt_fail = 3'h0;
                    nxt_fallback = 1'b0;
                    nxt_state = force_open_loop ? ST_OPEN : ST_CLOSED;
                end
            end
            ST_CLOSED: begin
                // Stop first; a good crossing then beats a miss,
                // so only an unbroken run of misses reaches the limit
                if (drive_stop) begin
                    nxt_state = ST_IDLE;
                end else if (zero_cross_event) begin
                    nxt_fail = 3'h0;
                end else if (zero_cross_miss && auto_en) begin
                    if (fail_hit) begin
                        nxt_state = ST_OPEN;
                        nxt_fallback = 1'b1;
                        nxt_fail = 3'h0;
                    end else begin
                        nxt_fail = fail_ff + 3'h1;
                    end
                end
            end
            ST_OPEN: begin
                if (drive_stop) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            fail_ff <= 3'h0;
        end else begin
            fail_ff <= nxt_fail;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            fallback_ff <= 1'b0;
        end else begin
            fallback_ff <= nxt_fallback;
        end
    end

    // Step counter: one unit every STEP_CYC clocks, about 24.6 us.
    // Rounding the step down to whole clocks leaves each unit
    // 15 ns short of the nominal step
    localparam logic [7:0] STEP_LAST = 8'(`STEP_CYC - 1);
    wire in_open = state_ff == ST_OPEN;
    wire step_end = step_ff == STEP_LAST;
    wire [9:0] unit_inc = unit_ff + 10'h001;
    wire [9:0] half_units = {1'b0, period_ff[9:1]};

    // The period ends after the full count of units, so an odd value
    // keeps its whole length; 0 and 1 end a period at every unit
    wire period_end = step_end && (unit_inc >= period_ff);
    // Phase goes high at mid-period and low again at its end
    wire half_hit = step_end && (unit_inc == half_units);

    // Counters rest at zero outside open loop, so each entry starts a
    // fresh period
    wire [7:0] nxt_step = (!in_open || step_end) ? 8'h00
        : step_ff + 8'h01;
    wire [9:0] nxt_unit = (!in_open || period_end) ? 10'h000
        : unit_ff + {9'h000, step_end};
    wire nxt_tick = in_open && period_end;
    wire nxt_phase = in_open && !period_end && (half_hit || phase_ff);

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            step_ff <= 8'h00;
        end else begin
            step_ff <= nxt_step;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            unit_ff <= 10'h000;
        end else begin
            unit_ff <= nxt_unit;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            tick_ff <= 1'b0;
        end else begin
            tick_ff <= nxt_tick;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            phase_ff <= 1'b0;
        end else begin
            phase_ff <= nxt_phase;
        end
    end

    assign loop_state = state_ff;
    assign open_loop_active = in_open;
    assign period_tick = tick_ff;
    assign drive_phase = phase_ff;
    // Fallback forces square until the next start; otherwise the
    // shape bit decides
    wire shape_bit = ctrl_ff[`BIT_SHAPE];
    wire force_square = fallback_ff || !shape_bit;
    assign drive_shape = force_square ? SHAPE_SQUARE : SHAPE_SINE;
endmodule

// ### verif/lra_ol_asserts.sv
`timescale 1ns/1ns
module lra_ol_asserts (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic drive_stop,
    input wire logic zero_cross_event,
    input wire logic zero_cross_miss,
    input wire lra_ol_pkg::loop_state_t loop_state,
    input wire lra_ol_pkg::shape_t drive_shape,
    input wire logic open_loop_active,
    input wire logic period_tick
);
    import lra_ol_pkg::*;
    logic [7:0] c_ff;
    logic [9:0] p_ff;
    logic [2:0] m_ff;
    logic [19:0] t_ff;
    logic g_ff;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // Shadow copies, so checks do not trust the design's own readback
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            c_ff <= 8'h00;
            p_ff <= 10'h0C6;
        end else if (reg_wr && reg_addr == 8'h2C) c_ff <= reg_wdata;
        else if (reg_wr && reg_addr == 8'h2E) p_ff[9:8] <= reg_wdata[1:0];
        else if (reg_wr && reg_addr == 8'h2F) p_ff[7:0] <= reg_wdata;
    end
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            m_ff <= 3'h0;
            t_ff <= 20'h0;
            g_ff <= 1'b0;
        end else begin
            if (loop_state != ST_CLOSED || zero_cross_event) m_ff <= 3'h0;
            else if (zero_cross_miss && c_ff[7]) m_ff <= m_ff + 3'h1;
            t_ff <= (period_tick || !open_loop_active) ? 20'h0 : t_ff + 20'h1;
            g_ff <= open_loop_active && !reg_wr && (g_ff || period_tick);
        end
    end
    a_no_auto_fallback: assert property (loop_state == ST_CLOSED && !c_ff[7]
        && !drive_stop |=> loop_state == ST_CLOSED) else $error("fell back");
    a_fallback_square: assert property ($past(loop_state) == ST_CLOSED &&
        loop_state == ST_OPEN |-> drive_shape == SHAPE_SQUARE) else $error("sq");
    a_miss_threshold: assert property (loop_state == ST_CLOSED && c_ff[7]
        && zero_cross_miss && !zero_cross_event && !drive_stop &&
        m_ff == c_ff[6:5] + 3'h2 |=> loop_state == ST_OPEN) else $error("thr");
    a_miss_cleared: assert property (loop_state == ST_CLOSED && !drive_stop
        && (m_ff < c_ff[6:5] + 3'h2 || zero_cross_event)
        |=> loop_state == ST_CLOSED) else $error("early fallback");
    a_shape_select: assert property ($past(loop_state) == ST_IDLE &&
        loop_state == ST_OPEN |-> drive_shape == shape_t'(c_ff[0]))
        else $error("shape");
    a_period_low: assert property (reg_addr == 8'h2F |->
        reg_rdata == p_ff[7:0]) else $error("low byte");
    a_period_high: assert property (reg_addr == 8'h2E |->
        reg_rdata == {6'h00, p_ff[9:8]}) else $error("high byte");
    a_tick_spacing: assert property (period_tick && g_ff |->
        t_ff == 20'(p_ff) * 20'h000F6 - 20'h1) else $error("period");
endmodule
bind lra_open_loop_fallback_ctrl lra_ol_asserts i_lra_ol_asserts (.*);

// ### verif/lra_model.sv
`timescale 1ns/1ns
// Actuator stand-in: crossing each cycle, every other one lost, all of them lost when bad
module lra_model (
    input wire logic sys_clk,
    input wire logic bad,
    output logic zero_cross_event,
    output logic zero_cross_miss
);
    logic t_ff;
    initial t_ff = 1'b0;
    always @(negedge sys_clk) t_ff <= !t_ff;
    assign zero_cross_event = t_ff && !bad;
    assign zero_cross_miss = !zero_cross_event;
endmodule

// ### verif/lra_open_loop_fallback_ctrl_tb_top.sv
`timescale 1ns/1ns
module lra_open_loop_fallback_ctrl_tb_top;
    import lra_ol_pkg::*;
    logic sys_clk, rst_b, reg_wr, drive_start, drive_stop, force_open_loop;
    logic zero_cross_event, zero_cross_miss, bad, open_loop_active;
    logic period_tick, drive_phase;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    loop_state_t loop_state;
    shape_t drive_shape;
    int fails = 0, cmp_count = 0, n, k, first;
    lra_open_loop_fallback_ctrl i_lra_open_loop_fallback_ctrl (.*);
    lra_model i_lra_model (.*);
    initial begin
        sys_clk = 0;
        forever #50 sys_clk = !sys_clk;
    end
    task chk(input logic [7:0] s, input logic [7:0] e);
        cmp_count++;
        if (s !== e) begin
            fails++;
            $display("FAIL %0t %h %h", $time, s, e);
        end
    endtask
    task tally_and_finish;
        $display("cmp_count=%0d fails=%0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
        @(negedge sys_clk);
        reg_wr = 0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge sys_clk);
        reg_addr = a;
        #20;
        chk(reg_rdata, e);
    endtask
    task pulse(input logic s, input logic f);
        @(negedge sys_clk);
        {drive_start, drive_stop, force_open_loop} = {s, !s, f};
        @(negedge sys_clk);
        {drive_start, drive_stop} = 2'h0;
    endtask
    initial begin
        {reg_wr, reg_addr, reg_wdata, drive_start, drive_stop} = 0;
        {force_open_loop, bad, rst_b} = 0;
        repeat (16) @(negedge sys_clk);
        rst_b = 1;
        rd(8'h2C, 8'h00);
        rd(8'h2F, 8'hC6);
        wr(8'h2E, 8'hFF);
        rd(8'h2E, 8'h03);
        wr(8'h2E, 8'h00);
        wr(8'h2F, 8'h04);
        wr(8'h2C, 8'h81);
        pulse(1, 0);
        repeat (40) @(negedge sys_clk);
        chk(loop_state, ST_CLOSED);
        pulse(0, 0);
        wr(8'h2C, 8'h01);
        bad = 1;
        pulse(1, 0);
        repeat (40) @(negedge sys_clk);
        chk(loop_state, ST_CLOSED);
        pulse(0, 0);
        for (int c = 0; c < 4; c++) begin
            wr(8'h2C, {1'b1, 2'(c), 5'h01});
            pulse(1, 0);
            repeat (2 + c) @(negedge sys_clk);
            chk(loop_state, ST_CLOSED);
            @(negedge sys_clk);
            chk(loop_state, ST_OPEN);
            chk(drive_shape, SHAPE_SQUARE);
            pulse(0, 0);
        end
        pulse(1, 1);
        chk(drive_shape, SHAPE_SINE);
        chk(open_loop_active, 1'b1);
        first = 0;
        for (n = 0, k = 0; k < 2 && n < 3000; n++) begin
            @(negedge sys_clk);
            if (period_tick) begin
                k++;
                chk(drive_phase, 1'b0);
                if (k == 1) first = n;
            end
        end
        chk(k, 2);
        chk((n - 1 - first) == 984, 1'b1);
        tally_and_finish;
    end
endmodule
